// ===== design/rdc_edge_det.sv
// Rising-edge detector for the count strobe
`timescale 1ns/1ns
`default_nettype none
module rdc_edge_det (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic level_in,
    output logic rise_pulse
);
    import rdc_pkg::*;

    rdc_edge_st_t st_q;
    rdc_edge_st_t st_d;

    always_comb begin
        case (st_q)
            RDC_ST_LOW: st_d = level_in ? RDC_ST_HIGH : RDC_ST_LOW;
            RDC_ST_HIGH: st_d = level_in ? RDC_ST_HIGH : RDC_ST_LOW;
            default: st_d = RDC_ST_LOW;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q <= RDC_ST_LOW;
        end else begin
            st_q <= st_d;
        end
    end

    // Combinational one-cycle enable; input is taken as synchronous
    assign rise_pulse = level_in && (st_q == RDC_ST_LOW);
endmodule : rdc_edge_det
`default_nettype wire

// ===== design/rdc_pkg.sv
// Constants and types shared by the reloading down-counter
`default_nettype none
package rdc_pkg;
    // =====================================================
    // Widths, reset values, terminal count and step
    localparam int unsigned RDC_CNT_W = 4;
    localparam logic [3:0] RDC_RELOAD_RST = 4'h0;
    localparam logic [3:0] RDC_COUNT_RST = 4'h0;
    localparam logic [3:0] RDC_TERMINAL = 4'h0;
    localparam logic [3:0] RDC_STEP = 4'h1;
    // =====================================================
    // Strobe edge detector states
    typedef enum logic [1:0] {
        RDC_ST_LOW = 2'b01,
        RDC_ST_HIGH = 2'b10
    } rdc_edge_st_t;
endpackage : rdc_pkg
`default_nettype wire

// ===== design/rdc_reloading_down_counter.sv
// Auto-reloading down-counter dividing the address-latch strobe
//
// Notes on behaviour
// - Host writes initial count into a four-bit reload register kept as source.
// - Stored reload value is transferred into separate four-bit down-counting register.
// - On reaching zero the counter reloads from reload register automatically.
// - Each decrement to zero drives a pulse on a dedicated output pin; a count of zero loaded from the reload register gives none.
// - Counter advances on the address-latch strobe, any signal could serve.
// - Host may write a new reload value any time, changing division ratio.
`timescale 1ns/1ns
`default_nettype none
module rdc_reloading_down_counter
#(
    parameter int unsigned CNT_W = rdc_pkg::RDC_CNT_W
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic count_strobe,
    input wire logic reload_wr,
    input wire logic [3:0] reload_wdata,
    output logic [3:0] reload_value,
    output logic [3:0] count_value,
    output logic terminal_pulse
);
    import rdc_pkg::*;

    // Ports are fixed at four bits, so any other width is refused here
    if (CNT_W != RDC_CNT_W) begin : g_width_check
        $error("rdc: only a 4-bit counter is supported");
    end

    // =====================================================
    // Terminal-count decode
    // Shared by the reload decision and the pulse flag
    function automatic logic rdc_is_terminal(input logic [3:0] value);
        return value == RDC_TERMINAL;
    endfunction : rdc_is_terminal

    // =====================================================
    // Count strobe edges
    logic strobe_en;

    // strobe rising edge as count enable
    // Strobe is taken as synchronous; a long high level still counts once
    rdc_edge_det u_edge (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .level_in(count_strobe),
        .rise_pulse(strobe_en)
    );

    // =====================================================
    // Reload and counting registers
    logic [3:0] reload_q;
    logic [3:0] reload_d;
    logic [3:0] count_q;
    logic [3:0] count_d;
    logic term_q;
    logic term_d;
    logic load_pend_q;
    logic load_pend_d;

    always_comb begin
        reload_d = reload_q;
        count_d = count_q;
        term_d = term_q;
        load_pend_d = load_pend_q;
        if (reload_wr) begin
            reload_d = reload_wdata;
            load_pend_d = 1'b1;
        end
        // Write on a strobe edge: the count steps with the old value now, the new one loads at the next edge
        if (strobe_en) begin
            term_d = 1'b0;
            if (load_pend_q) begin
                count_d = reload_q;
                load_pend_d = reload_wr;
            end else if (rdc_is_terminal(count_q)) begin
                count_d = reload_q;
            end else begin
                count_d = count_q - RDC_STEP;
                term_d = rdc_is_terminal(count_d);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reload_q <= RDC_RELOAD_RST;
            count_q <= RDC_COUNT_RST;
            term_q <= 1'b0;
            load_pend_q <= 1'b0;
        end else begin
            reload_q <= reload_d;
            count_q <= count_d;
            term_q <= term_d;
            load_pend_q <= load_pend_d;
        end
    end

    // Pulse holds from the strobe that reached zero until the next strobe
    // Zero is held one count period, so the ratio is the reload value plus one
    assign reload_value = reload_q;
    assign count_value = count_q;
    assign terminal_pulse = term_q;

    // =====================================================
    // Checks on the reload path
    // Antecedents of a_first_load and a_pend_clear use the internal count enable, so those checks only fire on a real edge

    property p_wr_stores;
        @(posedge sys_clk) disable iff (sys_rst)
        reload_wr |=> reload_value == $past(reload_wdata);
    endproperty
    a_wr_stores: assert property (p_wr_stores) else $error("reload write not stored");

    property p_reload_hold;
        @(posedge sys_clk) disable iff (sys_rst)
        !reload_wr |=> $stable(reload_value);
    endproperty
    a_reload_hold: assert property (p_reload_hold) else $error("reload value moved without a write");

    property p_pend_set;
        @(posedge sys_clk) disable iff (sys_rst)
        reload_wr |=> load_pend_q;
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("rewrite not scheduled");

    property p_rewrite_held;
        @(posedge sys_clk) disable iff (sys_rst)
        (load_pend_q && !strobe_en) |=> load_pend_q;
    endproperty
    a_rewrite_held: assert property (p_rewrite_held) else $error("pending reload lost");

    property p_first_load;
        @(posedge sys_clk) disable iff (sys_rst)
        (strobe_en && load_pend_q) |=> count_value == $past(reload_q);
    endproperty
    a_first_load: assert property (p_first_load) else $error("reload not transferred");

    property p_pend_clear;
        @(posedge sys_clk) disable iff (sys_rst)
        (strobe_en && load_pend_q && !reload_wr) |=> !load_pend_q;
    endproperty
    a_pend_clear: assert property (p_pend_clear) else $error("pending reload not cleared");

    // =====================================================
    // Checks on counting and the pulse

    property p_zero_reload;
        @(posedge sys_clk) disable iff (sys_rst)
        (strobe_en && !load_pend_q && count_q == 4'h0) |=> count_value == $past(reload_q);
    endproperty
    a_zero_reload: assert property (p_zero_reload) else $error("no reload at zero");

    property p_term_set;
        @(posedge sys_clk) disable iff (sys_rst)
        (strobe_en && !load_pend_q && count_q == 4'h1) |=> terminal_pulse;
    endproperty
    a_term_set: assert property (p_term_set) else $error("terminal pulse missing");

    property p_pulse_at_zero;
        @(posedge sys_clk) disable iff (sys_rst)
        terminal_pulse |-> count_value == 4'h0;
    endproperty
    a_pulse_at_zero: assert property (p_pulse_at_zero) else $error("terminal pulse with count not zero");

    property p_term_quiet;
        @(posedge sys_clk) disable iff (sys_rst)
        (strobe_en && (load_pend_q || count_q == 4'h0)) |=> !terminal_pulse;
    endproperty
    a_term_quiet: assert property (p_term_quiet) else $error("terminal pulse on a load");

    property p_no_strobe_hold;
        @(posedge sys_clk) disable iff (sys_rst)
        !strobe_en |=> $stable(count_value);
    endproperty
    a_no_strobe_hold: assert property (p_no_strobe_hold) else $error("count moved without strobe");

    property p_edge_once;
        @(posedge sys_clk) disable iff (sys_rst)
        strobe_en |=> !strobe_en;
    endproperty
    a_edge_once: assert property (p_edge_once) else $error("strobe level counted twice");

    property p_dec_one;
        @(posedge sys_clk) disable iff (sys_rst)
        (strobe_en && !load_pend_q && count_q != 4'h0) |=> count_value == $past(count_q) - 4'h1;
    endproperty
    a_dec_one: assert property (p_dec_one) else $error("decrement not by one");

    property p_term_drop;
        @(posedge sys_clk) disable iff (sys_rst)
        (terminal_pulse && strobe_en) |=> !terminal_pulse;
    endproperty
    a_term_drop: assert property (p_term_drop) else $error("terminal pulse too long");

    property p_pulse_hold;
        @(posedge sys_clk) disable iff (sys_rst)
        (terminal_pulse && !strobe_en) |=> terminal_pulse;
    endproperty
    a_pulse_hold: assert property (p_pulse_hold) else $error("terminal pulse too short");
endmodule : rdc_reloading_down_counter
`default_nettype wire

// ===== tb/rdc_host_model.sv
// Host bus model writing the reload register
`timescale 1ns/1ns
`default_nettype none
module rdc_host_model (
    input wire logic sys_clk,
    output logic reload_wr,
    output logic [3:0] reload_wdata
);
    initial begin
        reload_wr = 1'b0;
        reload_wdata = 4'h0;
    end
    task automatic write(input logic [3:0] v);
        @(posedge sys_clk);
        reload_wr <= 1'b1;
        reload_wdata <= v;
        @(posedge sys_clk);
        reload_wr <= 1'b0;
        // Released bus must not keep the last value
        reload_wdata <= ~v;
    endtask : write
endmodule : rdc_host_model
`default_nettype wire

// ===== tb/test_reloading_down_counter.sv
// Self-checking bench for the reloading down-counter
`timescale 1ns/1ns
`default_nettype none
module test_reloading_down_counter;
    import rdc_pkg::*;
    logic sys_clk;
    logic sys_rst;
    logic count_strobe;
    logic reload_wr;
    logic [3:0] reload_wdata;
    logic [3:0] reload_value;
    logic [3:0] count_value;
    logic terminal_pulse;
    int n_mismatch = 0;
    int num_checks = 0;
    rdc_reloading_down_counter i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .count_strobe(count_strobe),
        .reload_wr(reload_wr), .reload_wdata(reload_wdata), .reload_value(reload_value),
        .count_value(count_value), .terminal_pulse(terminal_pulse));
    rdc_host_model i_host (.sys_clk(sys_clk), .reload_wr(reload_wr), .reload_wdata(reload_wdata));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // ==========================================
    // Compare tasks
    task automatic check_out(input logic [3:0] c, input logic p);
        num_checks++;
        if (count_value !== c || terminal_pulse !== p) begin
            n_mismatch++;
            $display("Error %0t: count %h pulse %b", $time, count_value, terminal_pulse);
        end
    endtask : check_out
    task automatic check_reload(input logic [3:0] v);
        num_checks++;
        if (reload_value !== v) begin
            n_mismatch++;
            $display("Error %0t: reload %h", $time, reload_value);
        end
    endtask : check_reload
    // Long high level must still count only once
    task automatic strobe(input int high);
        @(posedge sys_clk);
        count_strobe <= 1'b1;
        repeat (high) @(posedge sys_clk);
        count_strobe <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask : strobe
    // ==========================================
    // Scenarios
    task automatic test_reset();
        #1;
        check_reload(RDC_RELOAD_RST);
        check_out(4'h0, 1'b0);
        strobe(1);
        check_out(4'h0, 1'b0);
        $display("test_reset done");
    endtask : test_reset
    task automatic test_cycle();
        i_host.write(4'h3);
        #1;
        check_reload(4'h3);
        strobe(1);
        check_out(4'h3, 1'b0);
        strobe(6);
        check_out(4'h2, 1'b0);
        strobe(1);
        check_out(4'h1, 1'b0);
        strobe(1);
        check_out(4'h0, 1'b1);
        strobe(1);
        check_out(4'h3, 1'b0);
        $display("test_cycle done");
    endtask : test_cycle
    task automatic test_rewrite();
        i_host.write(4'h1);
        strobe(1);
        check_out(4'h1, 1'b0);
        strobe(1);
        check_out(4'h0, 1'b1);
        strobe(1);
        check_out(4'h1, 1'b0);
        $display("test_rewrite done");
    endtask : test_rewrite
    // Write lands on the same edge as a count strobe, then two writes back to back
    task automatic test_write_on_strobe();
        fork
            i_host.write(4'h5);
            strobe(1);
        join
        check_reload(4'h5);
        check_out(4'h0, 1'b1);
        strobe(1);
        check_out(4'h5, 1'b0);
        strobe(1);
        check_out(4'h4, 1'b0);
        i_host.write(4'h7);
        i_host.write(4'h2);
        #1;
        check_reload(4'h2);
        strobe(1);
        check_out(4'h2, 1'b0);
        $display("test_write_on_strobe done");
    endtask : test_write_on_strobe
    // Reset in mid-run must also drop a pending reload
    task automatic test_mid_reset();
        i_host.write(4'h9);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1;
        check_reload(RDC_RELOAD_RST);
        check_out(RDC_COUNT_RST, 1'b0);
        strobe(1);
        check_out(RDC_RELOAD_RST, 1'b0);
        $display("test_mid_reset done");
    endtask : test_mid_reset
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        sys_rst = 1'b1;
        count_strobe = 1'b0;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        test_reset();
        test_cycle();
        test_rewrite();
        test_write_on_strobe();
        test_mid_reset();
        tally_and_finish();
    end
endmodule : test_reloading_down_counter
`default_nettype wire
